// *** design/fbk_flash_top.sv ***
// Purpose: flash bank access block: address map, fetch port with check code, timed program/erase
// Assumes: requester on mclk; apb master per protocol; small array stands for the flash cells
// Notes:   only WW low word bits per sector are stored, higher word bits alias
// Operation
// - erase clears a whole sector at once, never part of one
// - a bank holds one to sixteen sectors sharing one control path
// - program flash decodes as two 1.5 MB banks, low and high
// - emulation bank decodes as four 16 KB sectors at its own base
// - every bank word is 144 bits, data plus check codes
// - emulation bank programs while fetches run from program banks
// - instruction fetches from the emulation bank are refused
// - reads served on one bank while another bank programs or erases
// - engine carries out program and erase once software asks
// - pipelined mode raises fetch throughput
// - each 64-bit fetch returns its stored 8-bit check code
// - failing access address captured for software readback
// - one wide word programs in about 40 us
// - whole emulation bank programs in about 165 ms
// - durations include engine overhead, exclude data loading
// - bank erase takes 300, 240 and 80 ms nominal
`timescale 1ns/100ps
`default_nettype none
`include "fbk_regs.svh"
module fbk_flash_top #(
  parameter int unsigned WW              = 2,
  parameter int unsigned CW              = 24,
  parameter int unsigned SECT_ERASE_CYC  = `FBK_T_SECT_MS * `FBK_CLK_KHZ,
  parameter int unsigned LOW_ERASE_CYC   = `FBK_T_PLOW_MS * `FBK_CLK_KHZ,
  parameter int unsigned HIGH_ERASE_CYC  = `FBK_T_PHIGH_MS * `FBK_CLK_KHZ,
  parameter int unsigned EMU_ERASE_CYC   = `FBK_T_EMU_MS * `FBK_CLK_KHZ
) (
  // clock and reset
  input wire logic          mclk,
  input wire logic          srst,
  // apb slave
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pwrite,
  input wire logic [7:0]    paddr,
  input wire logic [31:0]   pwdata,
  output logic     [31:0]   prdata,
  output logic              pready,
  output logic              pslverr,
  // fetch port
  input wire logic          fetchReq,
  input wire logic          fetchInstr,
  input wire logic [31:0]   fetchAddr,
  output logic              fetchRdy,
  output logic              fetchAck,
  output logic              fetchErr,
  output logic     [63:0]   fetchData,
  output logic     [7:0]    fetchEcc,
  // check-code error event from requester
  input wire logic          eccErrEvt
);
  localparam int unsigned IW       = 6 + WW;
  localparam int unsigned WPS      = 1 << WW;
  localparam int unsigned PROG_CYC = (`FBK_T_PROG_US * `FBK_CLK_KHZ) / 1000;
  localparam int unsigned EE_TOT_CYC = `FBK_T_EE_TOT_MS * `FBK_CLK_KHZ;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  ////////////////////////////////////////////////////////////////////////
  // address decode into bank and sector
  function automatic fbk_pkg::fbk_loc_t decodeAddr(input logic [31:0] a);
    fbk_pkg::fbk_loc_t r;
    r = '{hit: 1'b0, bank: fbk_pkg::BK_NONE, sect: 4'h0};
    if (a < `FBK_B0_LARGE)
      r = '{1'b1, fbk_pkg::BK_PROGRAM_LOW, {2'b00, a[16:15]}};
    else if (a < `FBK_B1_BASE)
      r = '{1'b1, fbk_pkg::BK_PROGRAM_LOW, a[20:17] + 4'h3};
    else if (a < `FBK_PF_END)
      r = '{1'b1, fbk_pkg::BK_PROGRAM_HIGH, 4'(a[21:17] - 5'h0c)};
    else if (a >= `FBK_EE_BASE && a < `FBK_EE_END)
      r = '{1'b1, fbk_pkg::BK_EEPROM_EMU, {2'b00, a[15:14]}};
    return r;
  endfunction

  // nominal duration per operation and bank
  function automatic logic [CW-1:0] durFor(input fbk_pkg::fbk_op_t op, input fbk_pkg::fbk_bank_t bk);
    logic [CW-1:0] d;
    d = CW'(PROG_CYC);
    if (op == fbk_pkg::OP_SECT)
      d = CW'(SECT_ERASE_CYC);
    else if (op == fbk_pkg::OP_BANK)
      d = (bk == fbk_pkg::BK_PROGRAM_LOW)  ? CW'(LOW_ERASE_CYC) :
          (bk == fbk_pkg::BK_PROGRAM_HIGH) ? CW'(HIGH_ERASE_CYC) : CW'(EMU_ERASE_CYC);
    return d;
  endfunction

  // cell array: 144-bit words, two data halves and two check bytes
  logic [143:0]         memArr [1 << IW];
  logic [(1<<IW)-1:0]   validReg;

  logic                 pipeReg;
  logic [31:0]          addrReg;
  logic [31:0]          wdReg [4];
  logic [15:0]          weccReg;
  logic                 doneFlag;
  logic                 rejectFlag;
  logic                 eccErrFlag;
  logic [31:0]          errAddrReg;
  logic [31:0]          lastAddr;

  logic                 opActive;
  fbk_pkg::fbk_op_t     tgtOp;
  fbk_pkg::fbk_bank_t   tgtBank;
  logic [3:0]           tgtSect;
  logic [WW-1:0]        tgtWord;
  logic [143:0]         tgtData;

  logic                 setup;
  logic                 wrAcc;
  logic                 rdHit;
  logic [31:0]          rdMux;
  logic [2:0]           busyVec;
  fbk_pkg::fbk_op_t     cmdOp;
  fbk_pkg::fbk_loc_t    cmdLoc;
  logic                 cmdWr;

  fbk_op_if #(.CW(CW)) opIf ();

  fbk_pe_engine #(.CW(CW)) uEngine (
    .mclk (mclk),
    .srst (srst),
    .opIf (opIf.eng)
  );

  ////////////////////////////////////////////////////////////////////////
  // apb handshake: one wait-free access cycle after setup
  assign setup  = psel & ~penable;
  assign wrAcc  = psel & penable & pready & pwrite;
  assign cmdWr  = wrAcc && (paddr == `FBK_OFS_CTRL);
  assign cmdOp  = fbk_pkg::fbk_op_t'(pwdata[`FBK_CTRL_OP_LSB +: 2]);
  assign cmdLoc = decodeAddr(addrReg);
  assign busyVec = opActive ? 3'(1 << tgtBank) : 3'h0;

  // read mux for the register file
  always_comb begin
    rdMux = 32'h0;
    rdHit = 1'b1;
    unique case (paddr)
      `FBK_OFS_CTRL:    rdMux = {29'h0, pipeReg, (opActive ? tgtOp : fbk_pkg::OP_NONE)};
      `FBK_OFS_ADDR:    rdMux = addrReg;
      `FBK_OFS_WD0:     rdMux = wdReg[0];
      `FBK_OFS_WD1:     rdMux = wdReg[1];
      `FBK_OFS_WD2:     rdMux = wdReg[2];
      `FBK_OFS_WD3:     rdMux = wdReg[3];
      `FBK_OFS_WECC:    rdMux = {16'h0, weccReg};
      `FBK_OFS_STATUS:  rdMux = {26'h0, eccErrFlag, rejectFlag, doneFlag, busyVec};
      `FBK_OFS_ERRADDR: rdMux = errAddrReg;
      default:          rdHit = 1'b0;
    endcase
  end

  // answer registered at setup, shown in the access cycle
  always_ff @(posedge mclk) begin
    if (srst) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      prdata  <= (setup && !pwrite) ? rdMux : 32'h0;
      pslverr <= setup & ~rdHit;
    end
  end

  // plain storage registers
  always_ff @(posedge mclk) begin
    if (srst) begin
      pipeReg <= 1'(`FBK_CTRL_RST >> `FBK_CTRL_PIPE);
      addrReg <= `FBK_ADDR_RST;
      weccReg <= 16'h0;
      for (int i = 0; i < 4; i++) wdReg[i] <= 32'h0;
    end else if (wrAcc) begin
      if (paddr == `FBK_OFS_CTRL) pipeReg <= pwdata[`FBK_CTRL_PIPE];
      if (paddr == `FBK_OFS_ADDR) addrReg <= pwdata;
      if (paddr == `FBK_OFS_WECC) weccReg <= pwdata[15:0];
      for (int i = 0; i < 4; i++)
        if (paddr == 8'(`FBK_OFS_WD0 + 4 * i)) wdReg[i] <= pwdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // command launch: one operation at a time, shared control path
  always_ff @(posedge mclk) begin
    if (srst) begin
      opActive    <= 1'b0;
      opIf.start  <= 1'b0;
      opIf.op     <= fbk_pkg::OP_NONE;
      opIf.cycles <= '0;
      tgtOp       <= fbk_pkg::OP_NONE;
      tgtBank     <= fbk_pkg::BK_NONE;
      tgtSect     <= 4'h0;
      tgtWord     <= '0;
      tgtData     <= '0;
    end else begin
      opIf.start <= 1'b0;
      if (opIf.done) opActive <= 1'b0;
      if (cmdWr && cmdOp != fbk_pkg::OP_NONE && !opActive && cmdLoc.hit) begin
        opActive    <= 1'b1;
        opIf.start  <= 1'b1;
        opIf.op     <= cmdOp;
        opIf.cycles <= durFor(cmdOp, cmdLoc.bank);
        tgtOp       <= cmdOp;
        tgtBank     <= cmdLoc.bank;
        tgtSect     <= cmdLoc.sect;
        tgtWord     <= addrReg[4 +: WW];
        tgtData     <= {weccReg, wdReg[3], wdReg[2], wdReg[1], wdReg[0]};
      end
    end
  end

  // sticky status; a set in the clearing cycle wins
  always_ff @(posedge mclk) begin
    if (srst) begin
      doneFlag   <= 1'b0;
      rejectFlag <= 1'b0;
      eccErrFlag <= 1'b0;
    end else begin
      doneFlag   <= (doneFlag & ~(wrAcc && paddr == `FBK_OFS_STATUS && pwdata[`FBK_ST_DONE])) | opIf.done;
      rejectFlag <= (rejectFlag & ~(wrAcc && paddr == `FBK_OFS_STATUS && pwdata[`FBK_ST_REJECT]))
                  | (cmdWr && cmdOp != fbk_pkg::OP_NONE && (opActive || !cmdLoc.hit));
      eccErrFlag <= (eccErrFlag & ~(wrAcc && paddr == `FBK_OFS_STATUS && pwdata[`FBK_ST_ECCERR]))
                  | eccErrEvt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // cell update at the end of an operation
  always_ff @(posedge mclk) begin
    if (srst) begin
      validReg <= '0;
    end else if (opIf.done) begin
      unique case (tgtOp)
        fbk_pkg::OP_PROG: validReg[{tgtBank, tgtSect, tgtWord}] <= 1'b1;
        fbk_pkg::OP_SECT: validReg[{tgtBank, tgtSect, {WW{1'b0}}} +: WPS] <= '0;
        fbk_pkg::OP_BANK: validReg[{tgtBank, 4'h0, {WW{1'b0}}} +: 16 * WPS] <= '0;
        default: ;
      endcase
    end
  end

  // programming only clears bits of a word already written
  always_ff @(posedge mclk) begin
    if (opIf.done && tgtOp == fbk_pkg::OP_PROG)
      memArr[{tgtBank, tgtSect, tgtWord}] <= validReg[{tgtBank, tgtSect, tgtWord}]
        ? (memArr[{tgtBank, tgtSect, tgtWord}] & tgtData) : tgtData;
  end

  ////////////////////////////////////////////////////////////////////////
  // fetch port: stage 1 holds the request, stage 2 drives the answer
  logic              take;
  logic              s1Valid;
  logic              s1Instr;
  logic [31:0]       s1Addr;
  fbk_pkg::fbk_loc_t s1Loc;
  logic [IW-1:0]     s1Idx;
  logic              s1Bad;
  logic [63:0]       s1Data;
  logic [7:0]        s1Ecc;

  assign take   = fetchReq & fetchRdy;
  assign s1Loc  = decodeAddr(s1Addr);
  assign s1Idx  = {s1Loc.bank, s1Loc.sect, s1Addr[4 +: WW]};
  assign s1Bad  = ~s1Loc.hit
                | (s1Instr && s1Loc.bank == fbk_pkg::BK_EEPROM_EMU)
                | (opActive && s1Loc.bank == tgtBank);
  // erased words read as all ones, data and code alike
  assign s1Data = !validReg[s1Idx] ? 64'hffff_ffff_ffff_ffff :
                  s1Addr[3] ? memArr[s1Idx][127:64] : memArr[s1Idx][63:0];
  assign s1Ecc  = !validReg[s1Idx] ? 8'hff :
                  s1Addr[3] ? memArr[s1Idx][143:136] : memArr[s1Idx][135:128];

  // request stage; non-pipelined mode blocks one cycle after each take
  always_ff @(posedge mclk) begin
    if (srst) begin
      s1Valid  <= 1'b0;
      s1Instr  <= 1'b0;
      s1Addr   <= 32'h0;
      fetchRdy <= 1'b0;
    end else begin
      s1Valid  <= take;
      fetchRdy <= !(take && !pipeReg);
      if (take) begin
        s1Addr  <= fetchAddr;
        s1Instr <= fetchInstr;
      end
    end
  end

  // answer stage; other banks keep serving during an operation
  always_ff @(posedge mclk) begin
    if (srst) begin
      fetchAck  <= 1'b0;
      fetchErr  <= 1'b0;
      fetchData <= 64'h0;
      fetchEcc  <= 8'h0;
      lastAddr  <= 32'h0;
    end else begin
      fetchAck  <= s1Valid;
      fetchErr  <= s1Valid & s1Bad;
      fetchData <= (s1Valid && !s1Bad) ? s1Data : 64'h0;
      fetchEcc  <= (s1Valid && !s1Bad) ? s1Ecc : 8'h0;
      if (s1Valid) lastAddr <= s1Addr;
    end
  end

  // failing address: the last answered one when the requester reports
  always_ff @(posedge mclk) begin
    if (srst) errAddrReg <= 32'h0;
    else if (eccErrEvt) errAddrReg <= lastAddr;
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  a_sector_clear: assert property (
    opIf.done && tgtOp == fbk_pkg::OP_SECT |=> validReg[{tgtBank, tgtSect, {WW{1'b0}}} +: WPS] == '0)
    else $error("sector not fully erased");

  a_one_bank_busy: assert property (
    opActive |-> $onehot(busyVec) && (opIf.start || opIf.busy || opIf.done))
    else $error("control path shared by more than one operation");

  a_prog_map: assert property (
    s1Valid && s1Addr < `FBK_PF_END && !opActive |=> fetchAck && !fetchErr)
    else $error("program flash address refused");

  a_ee_instr: assert property (
    s1Valid && s1Instr && s1Addr >= `FBK_EE_BASE && s1Addr < `FBK_EE_END |=> fetchAck && fetchErr)
    else $error("instruction fetch served from emulation bank");

  a_ee_data: assert property (
    s1Valid && !s1Instr && s1Addr >= `FBK_EE_BASE && s1Addr < `FBK_EE_END && !opActive |=> !fetchErr)
    else $error("emulation bank data read refused");

  a_other_bank: assert property (
    s1Valid && opActive && s1Loc.hit && s1Loc.bank != tgtBank
    && !(s1Instr && s1Loc.bank == fbk_pkg::BK_EEPROM_EMU) |=> fetchAck && !fetchErr)
    else $error("read blocked by operation on another bank");

  a_ee_prog_fetch: assert property (
    opActive && tgtBank == fbk_pkg::BK_EEPROM_EMU && s1Valid && s1Instr && s1Loc.hit
    && s1Loc.bank != fbk_pkg::BK_EEPROM_EMU |=> fetchAck && !fetchErr)
    else $error("fetch stalled by emulation bank programming");

  a_busy_reject: assert property (
    s1Valid && opActive && s1Loc.bank == tgtBank |=> fetchErr && fetchData == 64'h0)
    else $error("read served from busy bank");

  a_pipe_rate: assert property (
    take |=> if (pipeReg) fetchRdy else (!fetchRdy ##1 fetchRdy))
    else $error("fetch ready pacing wrong for mode");

  a_ecc_word: assert property (
    s1Valid && !s1Bad |=> fetchAck && fetchEcc == $past(s1Ecc) && fetchData == $past(s1Data))
    else $error("check code not returned with fetched word");

  a_err_addr: assert property (
    eccErrEvt |=> errAddrReg == $past(lastAddr) && eccErrFlag)
    else $error("failing address not captured");

  a_start_run: assert property (
    opIf.start |=> opIf.busy)
    else $error("engine did not start");

  a_prog_len: assert property (
    opIf.start && opIf.op == fbk_pkg::OP_PROG |-> opIf.cycles == CW'(PROG_CYC) && PROG_CYC == 1600)
    else $error("word program length wrong");

  a_ee_total: assert property (
    opIf.start |-> (PROG_CYC * `FBK_EE_WORDS) <= EE_TOT_CYC)
    else $error("emulation bank program total exceeds nominal");

  a_erase_len: assert property (
    opIf.start && opIf.op == fbk_pkg::OP_BANK |->
      (tgtBank == fbk_pkg::BK_PROGRAM_LOW  && opIf.cycles == CW'(LOW_ERASE_CYC)) ||
      (tgtBank == fbk_pkg::BK_PROGRAM_HIGH && opIf.cycles == CW'(HIGH_ERASE_CYC)) ||
      (tgtBank == fbk_pkg::BK_EEPROM_EMU   && opIf.cycles == CW'(EMU_ERASE_CYC)))
    else $error("bank erase length wrong");
endmodule
`default_nettype wire

// *** design/fbk_op_if.sv ***
// Purpose: command and status between register side and program/erase engine
// Assumes: both ends on mclk
// Notes:   start is a one-cycle pulse, done a one-cycle pulse
`timescale 1ns/100ps
`default_nettype none
interface fbk_op_if #(
  parameter int unsigned CW = 24
) ();
  logic            start;
  fbk_pkg::fbk_op_t op;
  logic [CW-1:0]   cycles;
  logic            busy;
  logic            done;
  modport ctl (output start, op, cycles, input busy, done);
  modport eng (input start, op, cycles, output busy, done);
endinterface
`default_nettype wire

// *** design/fbk_pe_engine.sv ***
// Purpose: timed program/erase sequencer shared by all banks
// Assumes: start only while idle; cycles already hold the nominal duration
// Notes:   busy stays high for exactly cycles clock periods (one period for a count of 0), then done pulses
`timescale 1ns/100ps
`default_nettype none
module fbk_pe_engine #(
  parameter int unsigned CW = 24
) (
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // command side
  fbk_op_if.eng    opIf
);
  fbk_pkg::fbk_eng_st_t stateReg;
  logic [CW-1:0]        remainReg;
  logic [CW-1:0]        spanReg;
  logic [CW-1:0]        elapsedReg;

  ////////////////////////////////////////////////////////////////////////
  // sequencer: overhead is inside the count, data loading is not
  always_ff @(posedge mclk) begin
    if (srst) begin
      stateReg  <= fbk_pkg::ST_IDLE;
      remainReg <= '0;
      opIf.busy <= 1'b0;
      opIf.done <= 1'b0;
    end else begin
      opIf.done <= 1'b0;
      unique case (stateReg)
        fbk_pkg::ST_IDLE: begin
          if (opIf.start) begin
            stateReg  <= fbk_pkg::ST_RUN;
            remainReg <= opIf.cycles;
            opIf.busy <= 1'b1;
          end
        end
        fbk_pkg::ST_RUN: begin
          if (remainReg <= CW'(1)) begin
            stateReg  <= fbk_pkg::ST_IDLE;
            opIf.busy <= 1'b0;
            opIf.done <= 1'b1;
          end else begin
            remainReg <= remainReg - CW'(1);
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checking helpers: length asked for and length served
  always_ff @(posedge mclk) begin
    if (srst) begin
      spanReg    <= '0;
      elapsedReg <= '0;
    end else if (opIf.start && !opIf.busy) begin
      spanReg    <= opIf.cycles;
      elapsedReg <= '0;
    end else if (opIf.busy) begin
      elapsedReg <= elapsedReg + CW'(1);
    end
  end

  a_span_exact: assert property (@(posedge mclk) disable iff (srst)
    opIf.done |-> (elapsedReg == spanReg) || (spanReg == '0))
    else $error("operation length differs from requested count");

  a_busy_done: assert property (@(posedge mclk) disable iff (srst)
    $fell(opIf.busy) |-> opIf.done)
    else $error("busy fell without done");
endmodule
`default_nettype wire

// *** design/fbk_pkg.sv ***
// Purpose: shared types of the flash bank access block
// Assumes: nothing beyond the register header
// Notes:   constants live in fbk_regs.svh
package fbk_pkg;
  typedef enum logic [1:0] {OP_NONE, OP_PROG, OP_SECT, OP_BANK} fbk_op_t;
  typedef enum logic {ST_IDLE, ST_RUN} fbk_eng_st_t;
  typedef enum logic [1:0] {BK_PROGRAM_LOW, BK_PROGRAM_HIGH, BK_EEPROM_EMU, BK_NONE} fbk_bank_t;
  typedef struct packed {
    logic      hit;
    fbk_bank_t bank;
    logic [3:0] sect;
  } fbk_loc_t;
endpackage

// *** design/fbk_regs.svh ***
// Purpose: offsets, field positions, reset values and timing of the flash bank access block
// Assumes: 32-bit apb data, one aligned word per register
// Notes:   times are nominal figures; cycle counts are derived in the top module
`ifndef FBK_REGS_SVH
`define FBK_REGS_SVH

// register byte offsets
`define FBK_OFS_CTRL    8'h00
`define FBK_OFS_ADDR    8'h04
`define FBK_OFS_WD0     8'h08
`define FBK_OFS_WD1     8'h0c
`define FBK_OFS_WD2     8'h10
`define FBK_OFS_WD3     8'h14
`define FBK_OFS_WECC    8'h18
`define FBK_OFS_STATUS  8'h1c
`define FBK_OFS_ERRADDR 8'h20

// field positions
`define FBK_CTRL_OP_LSB 0
`define FBK_CTRL_PIPE   2
`define FBK_ST_DONE     3
`define FBK_ST_REJECT   4
`define FBK_ST_ECCERR   5

// reset values
`define FBK_CTRL_RST    32'h0000_0000
`define FBK_ADDR_RST    32'h0000_0000

// address map
`define FBK_B0_LARGE    32'h0002_0000
`define FBK_B1_BASE     32'h0018_0000
`define FBK_PF_END      32'h0030_0000
`define FBK_EE_BASE     32'hf020_0000
`define FBK_EE_END      32'hf021_0000
`define FBK_EE_WORDS    4096

// timing
`define FBK_CLK_KHZ     40000
`define FBK_T_PROG_US   40
`define FBK_T_EE_TOT_MS 165
`define FBK_T_SECT_MS   30
`define FBK_T_PLOW_MS   300
`define FBK_T_PHIGH_MS  240
`define FBK_T_EMU_MS    80

`endif

// *** test/fbk_flash_top_tb.sv ***
// Purpose: self-checking bench for the flash bank access block
// Assumes: apb master and requester model on mclk
// Notes:   erase counts shortened, program time kept at its nominal count
`timescale 1ns/100ps
`default_nettype none
`include "fbk_regs.svh"
module fbk_flash_top_tb;
  logic        mclk = 1'b0;
  logic        srst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, fetchAddr;
  logic        pready, pslverr, fetchReq, fetchInstr, fetchRdy, fetchAck, fetchErr, eccErrEvt, stuck;
  logic        monEn = 1'b0;
  logic        chkEn = 1'b0;
  logic        inject = 1'b0;
  logic [63:0] fetchData;
  logic [7:0]  fetchEcc;
  logic [72:0] fQ[$];
  logic [72:0] aQ[$];
  logic [31:0] wd[4];
  logic [15:0] we;
  logic [15:0] seed = 16'h46bf;
  int          miscompares = 0;
  int          check_count = 0;
  localparam logic [72:0] FF = {1'b0, 8'hff, 64'hffff_ffff_ffff_ffff};
  localparam logic [72:0] ER = {1'b1, 72'h0};

  always #12.5 mclk = ~mclk;

  fbk_flash_top #(.SECT_ERASE_CYC(20), .LOW_ERASE_CYC(30), .HIGH_ERASE_CYC(25), .EMU_ERASE_CYC(60))
  u_fbk_flash_top (.mclk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .fetchReq, .fetchInstr, .fetchAddr, .fetchRdy, .fetchAck, .fetchErr, .fetchData, .fetchEcc, .eccErrEvt);
  fbk_host_model u_fbk_host_model (.mclk, .srst, .fetchReq, .fetchInstr, .fetchAddr, .fetchRdy,
    .fetchAck, .fetchErr, .monEn, .chkEn, .inject, .eccErrEvt, .stuck);

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic check(input logic [72:0] seen, input logic [72:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // notes are taken oldest first; a bus answer with no note fails, a fetch refusal with no note passes
  always @(posedge mclk) begin
    if (fetchAck === 1'b1) check({fetchErr, fetchEcc, fetchData}, fQ.size() ? fQ.pop_front() : ~FF);
    if (pready === 1'b1) check({40'h0, pslverr, prdata}, aQ.size() ? aQ.pop_front() : ~FF);
  end

  // leading edge keeps two transfers from touching psel in one step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
    int n;
    aQ.push_back({40'h0, e});
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      miscompares++;
      tally_and_finish();
    end
  endtask

  task automatic fx(input logic i, input logic [31:0] a, input logic [72:0] e, input logic k);
    fQ.push_back(e);
    u_fbk_host_model.fetch(i, a, k);
    if (u_fbk_host_model.stuck) begin
      miscompares++;
      tally_and_finish();
    end
  endtask

  initial begin
    repeat (4) @(posedge mclk);
    srst <= 1'b0;
    // decode of both program banks, emulation bank and holes
    fx(0, 32'h0000_0000, FF, 0);
    fx(0, 32'h002f_fff8, FF, 0);
    fx(0, 32'h0030_0000, ER, 0);
    fx(1, `FBK_EE_BASE, ER, 0);
    fx(0, 32'hf020_fff8, FF, 0);
    fx(0, `FBK_EE_END, ER, 0);
    apb(0, 8'h40, 32'h0, {1'b1, 32'h0});
    $display("test decode done");
    // random wide word; the other bank serves reads meanwhile
    for (int k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      wd[k][31:16] = seed;
      seed = lfsr(seed);
      wd[k][15:0] = seed;
      apb(1, `FBK_OFS_WD0 + 8'(4 * k), wd[k], 33'h0);
    end
    seed = lfsr(seed);
    we = seed;
    apb(1, `FBK_OFS_WECC, {16'h0, we}, 33'h0);
    apb(1, `FBK_OFS_ADDR, 32'h0, 33'h0);
    apb(1, `FBK_OFS_CTRL, 32'h1, 33'h0);
    apb(0, `FBK_OFS_CTRL, 32'h0, 33'h1);
    fx(0, 32'h0018_0008, FF, 0);
    fx(0, 32'h0000_0008, ER, 0);
    repeat (1500) @(posedge mclk);
    apb(0, `FBK_OFS_STATUS, 32'h0, 33'h1);
    repeat (150) @(posedge mclk);
    apb(0, `FBK_OFS_STATUS, 32'h0, 33'h8);
    apb(1, `FBK_OFS_STATUS, 32'h8, 33'h0);
    fx(0, 32'h0, {1'b0, we[7:0], wd[1], wd[0]}, 0);
    fx(0, 32'h8, {1'b0, we[15:8], wd[3], wd[2]}, 0);
    $display("test program done");
    // sector erase returns both halves to the erased value
    apb(1, `FBK_OFS_CTRL, 32'h2, 33'h0);
    repeat (40) @(posedge mclk);
    apb(0, `FBK_OFS_STATUS, 32'h0, 33'h8);
    apb(1, `FBK_OFS_STATUS, 32'h8, 33'h0);
    fx(0, 32'h0, FF, 0);
    fx(0, 32'h8, FF, 0);
    $display("test sector erase done");
    // emulation bank erase under a pipelined burst; second start refused
    apb(1, `FBK_OFS_ADDR, `FBK_EE_BASE, 33'h0);
    apb(1, `FBK_OFS_CTRL, 32'h7, 33'h0);
    for (int k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      fx(1, `FBK_B1_BASE + {14'h0, seed, 2'h0}, FF, k < 3);
    end
    apb(1, `FBK_OFS_CTRL, 32'h5, 33'h0);
    apb(0, `FBK_OFS_STATUS, 32'h0, 33'h14);
    repeat (70) @(posedge mclk);
    apb(0, `FBK_OFS_STATUS, 32'h0, 33'h18);
    apb(1, `FBK_OFS_STATUS, 32'h18, 33'h0);
    $display("test bank erase done");
    // code error event counts only with the monitor bit set
    inject <= 1'b1;
    chkEn <= 1'b1;
    fx(0, 32'h0018_0010, FF, 0);
    // let the answer pass before the monitor bit goes up
    repeat (4) @(posedge mclk);
    apb(0, `FBK_OFS_STATUS, 32'h0, 33'h0);
    monEn <= 1'b1;
    fx(0, 32'h0018_0020, FF, 0);
    repeat (4) @(posedge mclk);
    apb(0, `FBK_OFS_ERRADDR, 32'h0, 33'h0018_0020);
    apb(0, `FBK_OFS_STATUS, 32'h0, 33'h20);
    $display("test error address done");
    repeat (4) @(posedge mclk);
    check({72'h0, stuck}, 73'h0);
    check(73'(fQ.size() + aQ.size()), 73'h0);
    tally_and_finish();
  end
endmodule
`default_nettype wire

// *** test/fbk_host_model.sv ***
// Purpose: requester on the fetch port of the flash bank block
// Assumes: mclk domain, a request is held until fetchRdy is seen high
// Notes:   raises a code error event only when the bench asks for one
`timescale 1ns/100ps
`default_nettype none
module fbk_host_model (
  // clock and reset
  input wire logic        mclk,
  input wire logic        srst,
  // fetch port
  output logic            fetchReq,
  output logic            fetchInstr,
  output logic     [31:0] fetchAddr,
  input wire logic        fetchRdy,
  input wire logic        fetchAck,
  input wire logic        fetchErr,
  // event control
  input wire logic        monEn,
  input wire logic        chkEn,
  input wire logic        inject,
  output logic            eccErrEvt,
  output logic            stuck
);
  logic held = 1'b0;

  // quiet outputs until the first request
  initial begin
    fetchReq = 1'b0;
    fetchInstr = 1'b0;
    fetchAddr = 32'h0;
    eccErrEvt = 1'b0;
    stuck = 1'b0;
  end

  // a mismatch is only signalled once the monitor bit is set
  always @(posedge mclk) begin
    eccErrEvt <= !srst && monEn && chkEn && inject && fetchAck && !fetchErr;
  end

  // keep leaves the request up so a burst has no gap
  task automatic fetch(input logic i, input logic [31:0] a, input logic keep);
    int n;
    if (!held) @(posedge mclk);
    fetchReq <= 1'b1;
    fetchInstr <= i;
    fetchAddr <= a;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (fetchRdy !== 1'b1 && n < 50);
    stuck = stuck | (n >= 50);
    held = keep;
    if (!keep) fetchReq <= 1'b0;
  endtask
endmodule
`default_nettype wire
